// ### design/sadc_ctrl.sv
// Sequencer and registers of the 8-bit successive-approximation converter control
`timescale 1ns/10ps
// Contract
// R1 - Mux routes one of fifteen channels
// R2 - Selected pin forced to converter input
// R3 - Claimed pin reads 0 or latch
// R4 - Conversion lasts sixteen converter clocks
// R5 - Control write starts on next edge
// R6 - Late write may delay start one edge
// R7 - Store result, then flag or interrupt
// R8 - Continuous mode overwrites result each conversion
// R9 - Single mode does one conversion only
// R10 - Flag set until result read
// R11 - Flag never set with interrupts enabled
// R12 - Interrupt cleared by result read or write
// R13 - Reset clears flag, interrupt, continuous enables
// R14 - Software writes zero to flag bit
// R15 - Software discards result after mid-conversion write
// R16 - Keeps running in wait, interrupt wakes
// R17 - Software powers down before wait
// R18 - Stop aborts conversion, resumes after exit
// R19 - Software allows one settling conversion
// R20 - Software avoids channel fourteen with timer clock
// R21 - Five-bit select: pins, references, power-off
// R22 - All-ones select powers off; reset value
// R23 - Three-bit prescale divides 1 to 16
// R24 - Result register updated whole
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int RES_W = SADC_RES_W,
  parameter int CONV_CLOCKS = SADC_CONV_CLOCKS
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire sadc_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic xtal_tick,
  input wire logic stop_mode,
  input wire logic [RES_W-1:0] sar_result,
  input wire logic sar_bit,
  output logic sar_sample,
  output logic sar_step,
  output logic sar_power_on,
  output logic [SADC_CHSEL_W-1:0] selected_analog_input,
  output logic conv_irq,
  input wire sadc_port_t port,
  output logic [SADC_NUM_PINS-1:0] adc_claim,
  output logic [SADC_NUM_PINS-1:0] port_read,
  output logic [SADC_NUM_PINS-1:0] port_drive_en
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (RES_W < 1 || RES_W > 8) begin : g_bad_width
    $error("RES_W must be 1 to 8");
  end
  if (CONV_CLOCKS < 2 || CONV_CLOCKS > 31) begin : g_bad_clocks
    $error("CONV_CLOCKS must be 2 to 31");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    sadc_state_t st;
    logic [4:0] cnt;
    logic done_flag;
    logic irq_en;
    logic cont_en;
    logic [SADC_CHSEL_W-1:0] chsel;
    logic [SADC_PRESC_W-1:0] presc;
    logic clk_src;
    logic [RES_W-1:0] result;
    logic irq;
    logic [7:0] rdata;
    logic sample;
    logic step;
    logic pwr;
    logic [SADC_NUM_PINS-1:0] claim;
    logic [SADC_NUM_PINS-1:0] rd_pins;
    logic [SADC_NUM_PINS-1:0] drv_en;
  } sadc_ctrl_t;

  sadc_ctrl_t s_q;
  sadc_ctrl_t s_d;

  logic conv_tick;
  logic src_tick;
  logic [SADC_NUM_PINS-1:0] claim_c;
  logic [SADC_NUM_PINS-1:0] rd_c;
  logic [SADC_NUM_PINS-1:0] drv_c;

  function automatic logic sadc_hit(input sadc_bus_req_t r, input logic [7:0] ofs);
    sadc_hit = (r.addr == ofs);
  endfunction : sadc_hit

  // ************************************************************
  // Converter clock and pin claim
  // ************************************************************
  // Bus clock source ticks every cycle; crystal source is a tick input
  assign src_tick = s_q.clk_src ? 1'b1 : xtal_tick;

  sadc_clk_div u_div (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .src_tick(src_tick),
    .clock_prescale(s_q.presc),
    .conv_tick(conv_tick)
  );

  sadc_pin_mux u_mux (
    .channel_select(s_q.chsel),
    .port(port),
    .claim(claim_c),
    .port_read(rd_c),
    .port_drive_en(drv_c)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  logic wr_ctl;
  logic rd_res;
  logic powered;

  always_comb begin
    s_d = s_q;
    wr_ctl = bus_req.wr && sadc_hit(bus_req, SADC_OFS_STATUS_CONTROL);
    rd_res = bus_req.rd && sadc_hit(bus_req, SADC_OFS_RESULT);
    powered = (s_q.chsel != SADC_CHSEL_OFF);  // [R22]
    s_d.sample = 1'b0;
    s_d.step = 1'b0;
    s_d.claim = claim_c;
    s_d.rd_pins = rd_c;
    s_d.drv_en = drv_c;

    // Reads: data valid exactly one cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus_req.rd) begin
      if (sadc_hit(bus_req, SADC_OFS_STATUS_CONTROL)) begin
        s_d.rdata[SADC_BIT_DONE] = s_q.done_flag & ~s_q.irq_en;  // [R11]
        s_d.rdata[SADC_BIT_IRQ_EN] = s_q.irq_en;
        s_d.rdata[SADC_BIT_CONT] = s_q.cont_en;
        s_d.rdata[SADC_CHSEL_LSB +: SADC_CHSEL_W] = s_q.chsel;
      end else if (sadc_hit(bus_req, SADC_OFS_RESULT)) begin
        s_d.rdata[RES_W-1:0] = s_q.result;  // [R24]
      end else if (sadc_hit(bus_req, SADC_OFS_CLOCK_SELECT)) begin
        s_d.rdata[SADC_PRESC_LSB +: SADC_PRESC_W] = s_q.presc;
        s_d.rdata[SADC_BIT_CLK_SRC] = s_q.clk_src;
      end
    end

    // Result read clears flag and interrupt; a completing conversion below wins
    if (rd_res) begin
      s_d.done_flag = 1'b0;  // [R10]
      s_d.irq = 1'b0;  // [R12]
    end

    if (bus_req.wr && sadc_hit(bus_req, SADC_OFS_CLOCK_SELECT)) begin
      s_d.presc = bus_req.wdata[SADC_PRESC_LSB +: SADC_PRESC_W];  // [R23]
      s_d.clk_src = bus_req.wdata[SADC_BIT_CLK_SRC];
    end

    // Sequencer
    case (s_q.st)
      SADC_IDLE: begin
      end
      SADC_ARM: begin
        // Wait for the next converter clock edge; a write just after an edge costs one
        if (conv_tick && powered) begin  // [R5] [R6]
          s_d.st = SADC_CONV;
          s_d.cnt = 5'h0;
          s_d.sample = 1'b1;
        end
      end
      SADC_CONV: begin
        if (conv_tick) begin
          s_d.step = 1'b1;
          if (s_q.cnt == 5'(CONV_CLOCKS - 1)) begin  // [R4]
            s_d.result = sar_result;  // [R7] [R8] [R24]
            if (s_q.irq_en) begin
              s_d.irq = 1'b1;  // [R12] [R16]
            end else begin
              s_d.done_flag = 1'b1;  // [R10] [R11]
            end
            s_d.st = s_q.cont_en ? SADC_ARM : SADC_IDLE;  // [R8] [R9]
          end else begin
            s_d.cnt = s_q.cnt + 5'h1;
          end
        end
      end
      default: begin
        s_d.st = SADC_IDLE;
      end
    endcase

    // Control write restarts; done flag bit of the write is ignored
    if (wr_ctl) begin
      s_d.irq_en = bus_req.wdata[SADC_BIT_IRQ_EN];
      s_d.cont_en = bus_req.wdata[SADC_BIT_CONT];
      s_d.chsel = bus_req.wdata[SADC_CHSEL_LSB +: SADC_CHSEL_W];  // [R21]
      s_d.irq = 1'b0;  // [R12]
      s_d.st = SADC_ARM;  // [R5]
      s_d.cnt = 5'h0;
    end

    // Powered off or stopped: abort, resume on exit from the armed state
    if (!powered || stop_mode) begin  // [R18] [R22]
      if (s_d.st == SADC_CONV) begin
        s_d.st = SADC_ARM;
      end
      s_d.sample = 1'b0;
      s_d.step = 1'b0;
    end
    s_d.pwr = (s_d.chsel != SADC_CHSEL_OFF) && !stop_mode;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= SADC_IDLE;
      s_q.chsel <= SADC_CHSEL_OFF;  // [R13] [R22]
      s_q.presc <= SADC_PRESC_RESET;
      s_q.clk_src <= SADC_CLK_SRC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rdata = s_q.rdata;
  assign conv_irq = s_q.irq;
  assign sar_sample = s_q.sample;
  assign sar_step = s_q.step;
  assign sar_power_on = s_q.pwr;
  assign selected_analog_input = s_q.chsel;  // [R1]
  assign adc_claim = s_q.claim;
  assign port_read = s_q.rd_pins;
  assign port_drive_en = s_q.drv_en;

  // Comparator bit is consumed by the analog core's register; unused here
  logic unused_bit;
  assign unused_bit = sar_bit;

endmodule : sadc_ctrl

// ### design/sadc_pkg.sv
// Package: register map, field layout, reset values and state types of the converter control
package sadc_pkg;

  // ************************************************************
  // Register map (byte offsets on the register port)
  // ************************************************************
  localparam logic [7:0] SADC_OFS_STATUS_CONTROL = 8'h38;
  localparam logic [7:0] SADC_OFS_RESULT = 8'h39;
  localparam logic [7:0] SADC_OFS_CLOCK_SELECT = 8'h3a;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SADC_BIT_DONE = 7;
  localparam int SADC_BIT_IRQ_EN = 6;
  localparam int SADC_BIT_CONT = 5;
  localparam int SADC_CHSEL_LSB = 0;
  localparam int SADC_CHSEL_W = 5;
  localparam int SADC_PRESC_LSB = 5;
  localparam int SADC_PRESC_W = 3;
  localparam int SADC_BIT_CLK_SRC = 4;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [4:0] SADC_CHSEL_OFF = 5'h1f;
  localparam logic [4:0] SADC_CHSEL_HIGH_REF = 5'h1d;
  localparam logic [4:0] SADC_CHSEL_LOW_REF = 5'h1e;
  localparam logic [4:0] SADC_CHSEL_LAST_PIN = 5'h0e;
  localparam logic [2:0] SADC_PRESC_RESET = 3'h0;
  localparam logic SADC_CLK_SRC_RESET = 1'b0;
  localparam int SADC_NUM_PINS = 15;
  localparam int SADC_CONV_CLOCKS = 16;
  localparam int SADC_RES_W = 8;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    SADC_IDLE = 3'b001,
    SADC_ARM = 3'b010,
    SADC_CONV = 3'b100
  } sadc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sadc_bus_req_t;

  typedef struct packed {
    logic [SADC_NUM_PINS-1:0] port_latch;
    logic [SADC_NUM_PINS-1:0] port_dir;
    logic [SADC_NUM_PINS-1:0] pin_in;
  } sadc_port_t;

endpackage : sadc_pkg

// ### design/sadc_clk_div.sv
// Converter clock prescaler producing one rising-edge tick per divided period
`timescale 1ns/10ps
module sadc_clk_div
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic src_tick,
  input wire logic [SADC_PRESC_W-1:0] clock_prescale,
  output logic conv_tick
);

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } sadc_div_t;

  sadc_div_t s_q;
  sadc_div_t s_d;

  // Divide ratio minus one: 1, 2, 4, 8, else 16
  function automatic logic [3:0] sadc_div_last(input logic [2:0] p);
    case (p)
      3'h0: sadc_div_last = 4'h0;
      3'h1: sadc_div_last = 4'h1;
      3'h2: sadc_div_last = 4'h3;
      3'h3: sadc_div_last = 4'h7;
      default: sadc_div_last = 4'hf;
    endcase
  endfunction : sadc_div_last

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (src_tick) begin
      if (s_q.cnt >= sadc_div_last(clock_prescale)) begin  // [R23]
        s_d.cnt = 4'h0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign conv_tick = s_q.tick;

endmodule : sadc_clk_div

// ### design/sadc_pin_mux.sv
// Pin claim: selected channel overrides port logic, read-back per direction bit
`timescale 1ns/10ps
module sadc_pin_mux
  import sadc_pkg::*;
(
  input wire logic [SADC_CHSEL_W-1:0] channel_select,
  input wire sadc_port_t port,
  output logic [SADC_NUM_PINS-1:0] claim,
  output logic [SADC_NUM_PINS-1:0] port_read,
  output logic [SADC_NUM_PINS-1:0] port_drive_en
);

  genvar g;
  generate
    for (g = 0; g < SADC_NUM_PINS; g++) begin : g_pin
      assign claim[g] = (channel_select == 5'(g));  // [R1] [R2]
      // Claimed pin: direction 0 reads 0, direction 1 reads the latch
      assign port_read[g] = claim[g] ? (port.port_dir[g] & port.port_latch[g])  // [R3]
                                     : (port.port_dir[g] ? port.port_latch[g] : port.pin_in[g]);
      assign port_drive_en[g] = port.port_dir[g] & ~claim[g];  // [R2]
    end
  endgenerate

endmodule : sadc_pin_mux

// ### verification/sadc_cpu_model.sv
// Partner model: processor side of the register port
`timescale 1ns/10ps
module sadc_cpu_model
  import sadc_pkg::*;
(
  input wire logic sys_clk,
  output sadc_bus_req_t bus_req
);
  initial bus_req = '0;
  // Released bus shows inverted values, so stale data never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, (a == SADC_OFS_STATUS_CONTROL) ? (d & 8'h7f) : d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '{~a, ~d, 1'b0, 1'b0};
  endtask : write
  task automatic read(input logic [7:0] a);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '{~a, 8'hff, 1'b0, 1'b0};
  endtask : read
endmodule : sadc_cpu_model

// ### verification/sadc_chk.sv
// Checker: port-level properties of the converter control
`timescale 1ns/10ps
module sadc_chk
  import sadc_pkg::*;
#(
  parameter int CONV_CLOCKS = SADC_CONV_CLOCKS
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire sadc_bus_req_t bus_req,
  input wire logic stop_mode,
  input wire sadc_port_t port,
  input wire logic sar_sample,
  input wire logic sar_step,
  input wire logic sar_power_on,
  input wire logic [SADC_CHSEL_W-1:0] selected_analog_input,
  input wire logic conv_irq,
  input wire logic [SADC_NUM_PINS-1:0] adc_claim,
  input wire logic [SADC_NUM_PINS-1:0] port_read,
  input wire logic [SADC_NUM_PINS-1:0] port_drive_en
);
  // ********
  // Steps since last start; a start pulse clears the count
  // ********
  logic [5:0] steps_q;
  logic [5:0] steps_d;
  logic [5:0] steps_now;
  logic [SADC_NUM_PINS-1:0] exp_claim;
  always_comb begin
    steps_now = steps_q + {5'h00, sar_step};
    steps_d = sar_sample ? 6'h00 : steps_now;
    exp_claim = (selected_analog_input > SADC_CHSEL_LAST_PIN) ? '0
      : 15'h0001 << selected_analog_input;
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      steps_q <= '0;
    end else begin
      steps_q <= steps_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_start_wr;
    bus_req.wr && bus_req.addr == SADC_OFS_STATUS_CONTROL
      && bus_req.wdata[4:0] != SADC_CHSEL_OFF && !stop_mode;
  endsequence
  // Completion near the access may legally set the request again
  sequence s_irq_clr;
    conv_irq && !sar_step && !$past(sar_step) && ((bus_req.wr
      && bus_req.addr == SADC_OFS_STATUS_CONTROL) || (bus_req.rd
      && bus_req.addr == SADC_OFS_RESULT));
  endsequence
  a_reset_vals:
    assert property (!$past(rst_b) |-> !conv_irq && !sar_power_on
      && selected_analog_input == SADC_CHSEL_OFF) else $error("outputs wrong after reset");
  a_start_soon:
    assert property (s_start_wr |-> ##[1:64] sar_sample) else $error("conversion never started");
  a_conv_len:
    assert property ($rose(conv_irq) |-> steps_now == 6'(CONV_CLOCKS))
    else $error("conversion length wrong");
  a_irq_clear:
    assert property (s_irq_clr |=> !conv_irq) else $error("interrupt not cleared");
  a_stop_idle:
    assert property (stop_mode && $past(stop_mode) |-> !sar_sample && !sar_step
      && !sar_power_on) else $error("converter active in stop");
  a_claim_sel:
    assert property ($stable(selected_analog_input) |-> adc_claim == exp_claim)
    else $error("pin claim wrong");
  a_pin_free:
    assert property ($past(rst_b) && $stable(port.port_dir) && $stable(adc_claim)
      |-> port_drive_en == (port.port_dir & ~adc_claim)) else $error("claimed pin driven");
  a_port_read:
    assert property ($past(rst_b) && $stable(port) && $stable(adc_claim)
      |-> port_read == ((port.port_dir & port.port_latch)
      | (~port.port_dir & ~adc_claim & port.pin_in))) else $error("port read wrong");
endmodule : sadc_chk
bind sadc_ctrl sadc_chk #(.CONV_CLOCKS(CONV_CLOCKS)) sadc_chk_i (.sys_clk, .rst_b, .bus_req,
  .stop_mode, .port, .sar_sample, .sar_step, .sar_power_on, .selected_analog_input,
  .conv_irq, .adc_claim, .port_read, .port_drive_en);

// ### verification/tb_top.sv
// Testbench: drives the converter control through its register port
`timescale 1ns/10ps
module tb_top;
  import sadc_pkg::*;
  // ********
  // Design, partner and checking
  // ********
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic xtal_tick = 1'b0;
  logic stop_mode = 1'b0;
  logic rd_seen = 1'b0;
  logic conv_irq;
  logic [7:0] sar_result = 8'h00;
  logic [7:0] rdata;
  logic [7:0] exp_q[$];
  sadc_port_t port = '0;
  sadc_bus_req_t bus_req;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 87;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  sadc_cpu_model sadc_cpu_model_i (.sys_clk, .bus_req);
  sadc_ctrl sadc_ctrl_i (.sys_clk, .rst_b, .bus_req, .rdata, .xtal_tick, .stop_mode,
    .sar_result, .sar_bit(1'b0), .sar_sample(), .sar_step(), .sar_power_on(),
    .selected_analog_input(), .conv_irq, .port, .adc_claim(), .port_read(),
    .port_drive_en());
  task automatic check8(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, want);
    end
  endtask : check8
  task automatic check_span(input int got, input int lo, input int hi);
    check8(8'(got >= lo && got <= hi), 8'h01);
  endtask : check_span
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sadc_cpu_model_i.write(a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    exp_q.push_back(want);
    sadc_cpu_model_i.read(a);
  endtask : rd
  task automatic wait_irq(output int n);
    n = 0;
    while (conv_irq !== 1'b1 && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_irq
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    xtal_tick <= ~xtal_tick;
    if (cyc[1:0] == 2'b00) port <= 45'({$random(seed), $random(seed)});
  end
  // Read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_seen <= bus_req.rd;
    if (rd_seen) check8(rdata, exp_q.pop_front());
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    logic [7:0] r;
    logic [4:0] ch;
    int n;
    int dv;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h38, 8'h1f);
    rd(8'h3a, 8'h00);
    rd(8'h40, 8'h00);
    $display("test done: reset values");
    // Timer clock input is not modelled, so channel fourteen is free here
    for (int i = 0; i < 17; i++) begin
      ch = (i < 15) ? 5'(i) : 5'(i + 14);
      dv = (i % 8 > 3) ? 16 : 1 << (i % 8);
      r = 8'($random(seed));
      sar_result <= r;
      wr(8'h3a, {3'(i % 8), 5'h10});
      wr(8'h38, {3'b010, ch});
      wait_irq(n);
      check_span(n, 16 * dv, 17 * dv + 6);
      rd(8'h38, {3'b010, ch});
      rd(8'h39, r);
      @(negedge sys_clk);
      check8({7'h00, conv_irq}, 8'h00);
    end
    $display("test done: channels and prescale");
    r = 8'($random(seed));
    sar_result <= r;
    wr(8'h3a, 8'h10);
    wr(8'h38, 8'h03);
    repeat (40) @(negedge sys_clk);
    rd(8'h38, 8'h83);
    rd(8'h38, 8'h83);
    rd(8'h39, r);
    rd(8'h38, 8'h03);
    repeat (40) @(negedge sys_clk);
    rd(8'h38, 8'h03);
    $display("test done: flag mode");
    wr(8'h3a, 8'h80);
    sar_result <= 8'h5a;
    wr(8'h38, 8'h22);
    repeat (1200) @(posedge sys_clk);
    sar_result <= 8'ha5;
    repeat (1200) @(negedge sys_clk);
    rd(8'h38, 8'ha2);
    rd(8'h39, 8'ha5);
    $display("test done: continuous");
    wr(8'h3a, 8'h10);
    wr(8'h38, 8'h45);
    repeat (8) @(posedge sys_clk);
    stop_mode <= 1'b1;
    repeat (30) @(negedge sys_clk);
    check8({7'h00, conv_irq}, 8'h00);
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    wait_irq(n);
    check_span(n, 16, 23);
    rd(8'h38, 8'h45);
    $display("test done: stop");
    wr(8'h38, 8'h46);
    repeat (5) @(posedge sys_clk);
    sar_result <= 8'hc3;
    wr(8'h38, 8'h47);
    wait_irq(n);
    check_span(n, 16, 23);
    wr(8'h38, 8'h9f);
    @(negedge sys_clk);
    check8({7'h00, conv_irq}, 8'h00);
    rd(8'h39, 8'hc3);
    rd(8'h38, 8'h1f);
    $display("test done: restart and power off");
    final_report();
  end
endmodule : tb_top
